// *** rtl/slc_pkg.sv ***
/*
  shared constants and types for the synthesizer lock and channel control block:
  register offsets, field positions, reset values, frequency mapping, timing counts,
  radio state encoding and the register request carrier.
  assumes a single 200 MHz clock domain; all users import the whole package.
*/
package slc_pkg;

  // register offsets on the host register port
  localparam logic [5:0] ADDR_CHAN_CTRL = 6'h08;  // channel_and_assessment_ctrl
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h0F;  // interrupt status (lock / unlock)
  localparam logic [5:0] ADDR_ALT_NUM = 6'h13;  // alt_frequency_number
  localparam logic [5:0] ADDR_ALT_BAND = 6'h14;  // alt_frequency_band
  localparam logic [5:0] ADDR_CF_CAL = 6'h1A;  // center_freq_calibration

  // field positions
  localparam int IRQ_LOCK_BIT = 0;  // lock event in status register
  localparam int IRQ_UNLOCK_BIT = 1;  // unexpected-unlock event
  localparam int CF_START_BIT = 7;  // cf_cal_start
  localparam int CHAN_MSB = 4;  // channel field 4:0
  localparam int BAND_MSB = 3;  // band select 3:0

  // reset values
  localparam logic [7:0] CHAN_CTRL_RST = 8'h2B;  // method 01, channel 0x0B
  localparam logic [7:0] ALT_NUM_RST = 8'h00;
  localparam logic [3:0] ALT_BAND_RST = 4'h0;
  localparam logic [6:0] CF_VALUE_RST = 7'h57;  // cf_cal_value bits 6:0

  // channel and band codes
  localparam logic [4:0] CH_FIRST = 5'h0B;
  localparam logic [4:0] CH_LAST = 5'h1A;
  localparam logic [3:0] BAND_STD = 4'h0;
  localparam logic [3:0] BAND_LOW = 4'h8;
  localparam logic [3:0] BAND_HIGH = 4'h9;
  localparam logic [7:0] NUM_LOW_MIN = 8'h20;
  localparam logic [7:0] NUM_HIGH_MAX = 8'hBA;

  // carrier frequency in 0.5 MHz units
  localparam logic [12:0] HALF_MHZ_CH_FIRST = 13'h12CA;  // 2405 MHz
  localparam logic [12:0] HALF_MHZ_CH_STEP = 13'h000A;  // 5 MHz
  localparam logic [12:0] HALF_MHZ_BAND_LOW = 13'h1204;  // 2306 MHz
  localparam logic [12:0] HALF_MHZ_BAND_HIGH = 13'h1304;  // 2434 MHz

  // timing
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int T_CF_CAL_NS = 8000;  // typical cf calibration
  localparam int T_TX_RX_SETTLE_NS = 32000;  // settle back after transmit
  localparam int CF_CAL_CYC = T_CF_CAL_NS / CLOCK_PERIOD_NS;
  localparam int TX_RX_SETTLE_CYC = T_TX_RX_SETTLE_NS / CLOCK_PERIOD_NS;

  // radio states seen by this block
  typedef enum logic [3:0] {
    ST_RADIO_IDLE,
    ST_SYNTH_READY,
    ST_LISTEN,
    ST_ARETRY_READY,
    ST_AACK_LISTEN,
    ST_TRANSMITTING,
    ST_ARETRY_TRANSMITTING,
    ST_RECEIVING,
    ST_AACK_RECEIVING
  } slc_state_t;

  // one register access per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } slc_reg_req_t;

endpackage : slc_pkg

// *** rtl/slc_ctrl.sv ***
/*
  synthesizer lock/unlock event reporting, radio state reaction to loss of lock,
  channel / alternative band selection and manual center-frequency calibration.
  assumes: register requests one per cycle on REG_REQ, read data one cycle later;
  PLL_LOCKED and radio events are synchronous to CLOCK.
*/
`timescale 1ns/10ps
`default_nettype none

module slc_ctrl
  import slc_pkg::*;
#(
  parameter int SETTLE_CYCLES = TX_RX_SETTLE_CYC
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire slc_reg_req_t REG_REQ,
  output logic [7:0] REG_RDATA,
  input wire logic STATE_CMD_VALID,
  input wire slc_state_t STATE_CMD,
  input wire logic TX_START,
  input wire logic TX_DONE,
  input wire logic RX_START,
  input wire logic RX_DONE,
  input wire logic PLL_LOCKED,
  output slc_state_t RADIO_STATE,
  output logic TX_ABORT,
  output logic CF_CAL_RUN,
  output logic FREQ_CHANGE,
  output logic [12:0] FREQ_HALF_MHZ,
  output logic FREQ_VALID,
  output logic [1:0] IRQ_FLAGS
);

  localparam int SW = $clog2(SETTLE_CYCLES + 1);  // settle counter width

  // refuse a settle count the counter cannot serve
  generate
    if (SETTLE_CYCLES < 1) begin : g_bad_settle
      $error("SETTLE_CYCLES must be at least one");
    end
    // the calibration counter is 11 bits wide and the run checks want eight cycles
    if (CF_CAL_CYC < 8 || CF_CAL_CYC > 2047) begin : g_bad_cal
      $error("CF_CAL_CYC does not fit the calibration counter");
    end
  endgenerate

  // registers
  logic [7:0] chan_ctrl_q;  // method bits and channel field
  logic [7:0] alt_num_q;  // alt_freq_index
  logic [3:0] alt_band_q;  // alt_freq_band_select
  logic [6:0] cf_value_q;  // cf_cal_value low bits, plain storage
  logic lock_irq_q;  // pending lock event
  logic unlock_irq_q;  // pending unlock event
  logic cal_run_q;  // calibration running, reads back as start bit
  logic [10:0] cal_cnt_q;  // calibration cycle count
  logic [SW-1:0] settle_cnt_q;  // post-transmit settling count
  logic relock_wait_q;  // receiving, waiting for lock to return
  logic pll_locked_q;  // previous lock level for edge detect
  slc_state_t state_q;
  slc_state_t state_d;
  logic [7:0] rdata_q;
  logic [12:0] freq_q;
  logic freq_valid_q;
  logic abort_q;
  logic freq_chg_q;

  // register decode
  wire wr_chan = REG_REQ.wr && (REG_REQ.addr == ADDR_CHAN_CTRL);
  wire wr_num = REG_REQ.wr && (REG_REQ.addr == ADDR_ALT_NUM);
  wire wr_band = REG_REQ.wr && (REG_REQ.addr == ADDR_ALT_BAND);
  wire wr_cf = REG_REQ.wr && (REG_REQ.addr == ADDR_CF_CAL);
  wire rd_irq = REG_REQ.rd && (REG_REQ.addr == ADDR_IRQ_STATUS);

  // next values of the frequency fields
  wire [7:0] chan_d = wr_chan ? REG_REQ.wdata : chan_ctrl_q;
  wire [7:0] num_d = wr_num ? REG_REQ.wdata : alt_num_q;
  wire [3:0] band_d = wr_band ? REG_REQ.wdata[BAND_MSB:0] : alt_band_q;

  // frequency selection; the number is ignored while band is zero
  wire [7:0] sel_q = (alt_band_q == BAND_STD) ? {3'h0, chan_ctrl_q[CHAN_MSB:0]} : alt_num_q;
  wire [7:0] sel_d = (band_d == BAND_STD) ? {3'h0, chan_d[CHAN_MSB:0]} : num_d;
  wire freq_chg = (band_d != alt_band_q) || (sel_d != sel_q);

  // state groups
  wire st_ready = (state_q == ST_SYNTH_READY) || (state_q == ST_LISTEN) ||
                  (state_q == ST_ARETRY_READY) || (state_q == ST_AACK_LISTEN);
  wire st_plain = (state_q == ST_SYNTH_READY) || (state_q == ST_LISTEN);
  wire st_tx = (state_q == ST_TRANSMITTING) || (state_q == ST_ARETRY_TRANSMITTING);
  wire st_rx = (state_q == ST_RECEIVING) || (state_q == ST_AACK_RECEIVING);
  wire st_idle = (state_q == ST_RADIO_IDLE);

  // lock edges from the synthesizer
  wire lock_rise = PLL_LOCKED && !pll_locked_q;
  wire lock_fall = !PLL_LOCKED && pll_locked_q;
  wire settling = (settle_cnt_q != '0);

  // calibration control; a zero write while running is simply not a start
  wire cal_start = wr_cf && REG_REQ.wdata[CF_START_BIT] && !cal_run_q;
  wire cal_done = cal_run_q && (cal_cnt_q == 11'(CF_CAL_CYC - 1));

  // event sources
  wire lock_evt = (lock_rise && !st_idle && !settling) || cal_done;
  wire unlock_evt = (st_plain && (cal_start || freq_chg)) ||
                    (lock_fall && !st_idle && !settling);

  // status flags: newest event wins, an event beats the read clear
  wire lock_irq_d = lock_evt && !unlock_evt ? 1'b1 :
                    unlock_evt ? 1'b0 : (rd_irq ? 1'b0 : lock_irq_q);
  wire unlock_irq_d = unlock_evt ? 1'b1 :
                      lock_evt ? 1'b0 : (rd_irq ? 1'b0 : unlock_irq_q);

  // command acceptance: only from a quiet state
  wire cmd_ok = STATE_CMD_VALID && (st_idle || st_ready) &&
                ((STATE_CMD == ST_RADIO_IDLE) || (STATE_CMD == ST_SYNTH_READY) ||
                 (STATE_CMD == ST_LISTEN) || (STATE_CMD == ST_ARETRY_READY) ||
                 (STATE_CMD == ST_AACK_LISTEN));
  wire tx_abort = st_tx && lock_fall;
  wire tx_ok_end = st_tx && TX_DONE && !lock_fall;

  // radio state transitions
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RADIO_IDLE: begin
        if (cmd_ok) state_d = STATE_CMD;
      end
      ST_SYNTH_READY: begin
        if (TX_START) state_d = ST_TRANSMITTING;
        else if (cmd_ok) state_d = STATE_CMD;
      end
      ST_ARETRY_READY: begin
        if (TX_START) state_d = ST_ARETRY_TRANSMITTING;
        else if (cmd_ok) state_d = STATE_CMD;
      end
      ST_LISTEN: begin
        if (RX_START) state_d = ST_RECEIVING;
        else if (cmd_ok) state_d = STATE_CMD;
      end
      ST_AACK_LISTEN: begin
        if (RX_START) state_d = ST_AACK_RECEIVING;
        else if (cmd_ok) state_d = STATE_CMD;
      end
      ST_TRANSMITTING: begin
        if (tx_abort || TX_DONE) state_d = ST_SYNTH_READY;
      end
      ST_ARETRY_TRANSMITTING: begin
        if (tx_abort) state_d = ST_SYNTH_READY;
        else if (TX_DONE) state_d = ST_ARETRY_READY;
      end
      ST_RECEIVING: begin
        // a frame done or relock after loss both return to listening
        if (RX_DONE || (relock_wait_q && lock_rise)) state_d = ST_LISTEN;
      end
      ST_AACK_RECEIVING: begin
        if (RX_DONE || (relock_wait_q && lock_rise)) state_d = ST_AACK_LISTEN;
      end
      default: state_d = ST_RADIO_IDLE;
    endcase
  end

  // register file
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      chan_ctrl_q <= CHAN_CTRL_RST;
      alt_num_q <= ALT_NUM_RST;
      alt_band_q <= ALT_BAND_RST;
      cf_value_q <= CF_VALUE_RST;
    end else begin
      chan_ctrl_q <= chan_d;
      alt_num_q <= num_d;
      alt_band_q <= band_d;
      if (wr_cf) cf_value_q <= REG_REQ.wdata[6:0];
    end
  end

  // event flags
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      lock_irq_q <= 1'b0;
      unlock_irq_q <= 1'b0;
    end else begin
      lock_irq_q <= lock_irq_d;
      unlock_irq_q <= unlock_irq_d;
    end
  end

  // calibration timer: count cleared at start, run flag cleared the cycle it ends, count held
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      cal_run_q <= 1'b0;
      cal_cnt_q <= 11'h000;
    end else if (cal_start) begin
      cal_run_q <= 1'b1;
      cal_cnt_q <= 11'h000;
    end else if (cal_done) begin
      cal_run_q <= 1'b0;
    end else if (cal_run_q) begin
      cal_cnt_q <= cal_cnt_q + 11'h001;
    end
  end

  // post-transmit settling window; its lock edges are the tx/rx frequency step
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      settle_cnt_q <= '0;
    end else if (tx_ok_end) begin
      settle_cnt_q <= SW'(SETTLE_CYCLES);
    end else if (settling) begin
      settle_cnt_q <= settle_cnt_q - SW'(1);
    end
  end

  // radio state, relock tracking, one-cycle pulses
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_RADIO_IDLE;
      relock_wait_q <= 1'b0;
      pll_locked_q <= 1'b0;
      abort_q <= 1'b0;
      freq_chg_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pll_locked_q <= PLL_LOCKED;
      abort_q <= tx_abort;
      freq_chg_q <= freq_chg;
      if (st_rx && lock_fall) relock_wait_q <= 1'b1;
      else if (!st_rx || lock_rise) relock_wait_q <= 1'b0;
    end
  end

  // carrier frequency in half-MHz units and its validity
  wire [12:0] ch_off = 13'(chan_ctrl_q[CHAN_MSB:0] - CH_FIRST) * HALF_MHZ_CH_STEP;
  wire ch_ok = (chan_ctrl_q[CHAN_MSB:0] >= CH_FIRST) && (chan_ctrl_q[CHAN_MSB:0] <= CH_LAST);
  wire [12:0] freq_std = HALF_MHZ_CH_FIRST + ch_off;
  wire [12:0] freq_low = HALF_MHZ_BAND_LOW + {5'h00, alt_num_q};
  wire [12:0] freq_high = HALF_MHZ_BAND_HIGH + {5'h00, alt_num_q};
  wire [12:0] freq_sel = (alt_band_q == BAND_STD) ? freq_std :
                         (alt_band_q == BAND_LOW) ? freq_low : freq_high;
  wire freq_ok = (alt_band_q == BAND_STD) ? ch_ok :
                 (alt_band_q == BAND_LOW) ? (alt_num_q >= NUM_LOW_MIN) :
                 (alt_band_q == BAND_HIGH) ? (alt_num_q <= NUM_HIGH_MAX) : 1'b0;

  // read mux; unmapped offsets read zero
  wire [7:0] rd_mux = (REG_REQ.addr == ADDR_CHAN_CTRL) ? chan_ctrl_q :
                      (REG_REQ.addr == ADDR_IRQ_STATUS) ? {6'h00, unlock_irq_q, lock_irq_q} :
                      (REG_REQ.addr == ADDR_ALT_NUM) ? alt_num_q :
                      (REG_REQ.addr == ADDR_ALT_BAND) ? {4'h0, alt_band_q} :
                      (REG_REQ.addr == ADDR_CF_CAL) ? {cal_run_q, cf_value_q} : 8'h00;

  // registered data outputs
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= 8'h00;
      freq_q <= 13'h0000;
      freq_valid_q <= 1'b0;
    end else begin
      if (REG_REQ.rd) rdata_q <= rd_mux;
      freq_q <= freq_sel;
      freq_valid_q <= freq_ok;
    end
  end

  assign REG_RDATA = rdata_q;
  assign RADIO_STATE = state_q;
  assign TX_ABORT = abort_q;
  assign CF_CAL_RUN = cal_run_q;
  assign FREQ_CHANGE = freq_chg_q;
  assign FREQ_HALF_MHZ = freq_q;
  assign FREQ_VALID = freq_valid_q;
  assign IRQ_FLAGS = {unlock_irq_q, lock_irq_q};

  // run length as the checks see it; kept apart from cal_cnt_q so that
  // a fault in the calibration counter cannot hide behind its own value
  logic [10:0] cal_seen_len_q;  // cycles the start bit has read one
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      cal_seen_len_q <= 11'h000;
    end else if (!cal_run_q) begin
      cal_seen_len_q <= 11'h000;  // idle: start again from zero
    end else begin
      cal_seen_len_q <= cal_seen_len_q + 11'h001;
    end
  end

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  flags_exclusive_a: assert property (!(lock_irq_q && unlock_irq_q))
    else $error("lock and unlock flags both set");
  unlock_on_cal_a: assert property (st_plain && cal_start |=> unlock_irq_q && !lock_irq_q)
    else $error("calibration start in ready state did not raise unlock");
  lock_on_done_a: assert property (cal_done && !unlock_evt |=> lock_irq_q && !cal_run_q)
    else $error("calibration end did not raise lock and clear start");
  cal_length_a: assert property ($fell(cal_run_q) |-> cal_seen_len_q == 11'(CF_CAL_CYC))
    else $error("calibration length out of range");
  cal_min_a: assert property ($rose(cal_run_q) |-> cal_run_q [*8])
    else $error("calibration ended too early");
  cal_bound_a: assert property (cal_run_q |-> cal_seen_len_q < 11'(CF_CAL_CYC))
    else $error("calibration ran too long");
  tx_abort_a: assert property (st_tx && lock_fall |=> state_q == ST_SYNTH_READY && TX_ABORT)
    else $error("lost lock in transmit did not abort");
  rx_relock_a: assert property (state_q == ST_RECEIVING && relock_wait_q && lock_rise && !RX_DONE
    |=> state_q == ST_LISTEN)
    else $error("receive did not return to listen after relock");
  settle_quiet_a: assert property (settling && !cal_done && !$past(lock_irq_q) |=> !$rose(lock_irq_q)
    or $past(lock_irq_q))
    else $error("lock event raised while settling");
  zero_write_a: assert property (cal_run_q && wr_cf && !REG_REQ.wdata[CF_START_BIT] && !cal_done
    |=> cal_run_q)
    else $error("zero write stopped calibration");
  std_select_a: assert property (alt_band_q == BAND_STD && chan_ctrl_q[CHAN_MSB:0] == CH_FIRST
    |=> FREQ_HALF_MHZ == HALF_MHZ_CH_FIRST && FREQ_VALID)
    else $error("standard channel frequency wrong");
  reserved_band_a: assert property (alt_band_q != BAND_STD && alt_band_q != BAND_LOW &&
    alt_band_q != BAND_HIGH |=> !FREQ_VALID)
    else $error("reserved band reported valid");
  abort_pulse_a: assert property (TX_ABORT |=> !TX_ABORT)
    else $error("abort pulse longer than one cycle");
  settle_load_a: assert property (tx_ok_end |=> settling && !st_tx)
    else $error("successful transmit did not open settle window");
  relock_event_a: assert property (lock_rise && !st_idle && !settling && !unlock_evt
    |=> lock_irq_q && !unlock_irq_q)
    else $error("relock did not raise lock event");

endmodule : slc_ctrl

`default_nettype wire

// *** tb/slc_ctrl_test.sv ***
/*
  self-checking bench for slc_ctrl: register reset values, channel and band mapping
  under random writes, lock/unlock events, calibration run, radio state reactions.
  assumes the design's own assertions guard its internals; bench drives all ports.
*/
`timescale 1ns/10ps
`default_nettype none
module slc_ctrl_test;
  import slc_pkg::*;
  logic clock, resetn, state_cmd_valid, pll_locked, tx_start, tx_done, rx_start, rx_done;
  slc_reg_req_t reg_req;
  slc_state_t state_cmd, radio_state;
  logic [7:0] reg_rdata, rd, ch_q, num_q, band_q;
  logic tx_abort, cf_cal_run, freq_change, freq_valid;
  logic [12:0] freq_half_mhz;
  logic [1:0] irq_flags; // {unlock, lock}
  logic [31:0] lfsr_q;
  int miscompares = 0;
  int total_checks = 0;
  // short settle window keeps the run brief
  slc_ctrl #(.SETTLE_CYCLES(8)) u_dut (.CLOCK(clock), .RESETN(resetn), .REG_REQ(reg_req),
    .REG_RDATA(reg_rdata), .STATE_CMD_VALID(state_cmd_valid), .STATE_CMD(state_cmd),
    .TX_START(tx_start), .TX_DONE(tx_done), .RX_START(rx_start), .RX_DONE(rx_done),
    .PLL_LOCKED(pll_locked), .RADIO_STATE(radio_state), .TX_ABORT(tx_abort),
    .CF_CAL_RUN(cf_cal_run), .FREQ_CHANGE(freq_change), .FREQ_HALF_MHZ(freq_half_mhz),
    .FREQ_VALID(freq_valid), .IRQ_FLAGS(irq_flags));
  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // galois step, taps chosen for a long period
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return (x >> 1) ^ (x[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction : lfsr_next
  // {valid, carrier in half MHz} from the documented mapping
  function automatic logic [13:0] exp_freq(input logic [4:0] c, input logic [3:0] b,
                                           input logic [7:0] n);
    if (b == 4'h0) return {(c >= 5'h0b) && (c <= 5'h1a), 13'h12ca + 13'(c - 5'h0b) * 13'h000a};
    if (b == 4'h8) return {n >= 8'h20, 13'h1204 + 13'(n)};
    if (b == 4'h9) return {n <= 8'hba, 13'h1304 + 13'(n)};
    return 14'h0000; // reserved band
  endfunction : exp_freq
  task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
    total_checks++;
    if (seen !== expv) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : chk
  task automatic test_done();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // write held for one cycle, returns just after the taking edge
  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock) reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock) reg_req <= '0;
    #1;
  endtask : reg_wr
  task automatic reg_rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clock) reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock) reg_req <= '0;
    tick(1);
    d = reg_rdata;
  endtask : reg_rd
  // {tx_start, tx_done, rx_start, rx_done} one-cycle pulses
  task automatic pulse(input logic [3:0] m);
    @(posedge clock) {tx_start, tx_done, rx_start, rx_done} <= m;
    @(posedge clock) {tx_start, tx_done, rx_start, rx_done} <= 4'h0;
    tick(1);
  endtask : pulse
  task automatic go(input slc_state_t s);
    @(posedge clock);
    state_cmd_valid <= 1'b1;
    state_cmd <= s;
    @(posedge clock) state_cmd_valid <= 1'b0;
    tick(1);
    chk(16'(radio_state), 16'(s));
  endtask : go
  task automatic pll(input logic v);
    @(posedge clock) pll_locked <= v;
    tick(3);
  endtask : pll
  // watchdog: whole run needs well under 10000 cycles
  initial begin
    #100000;
    miscompares++;
    test_done();
  end
  initial begin : main
    logic [13:0] ef;
    logic [11:0] key;
    int fc;
    time t0;
    logic [31:0] num_edges;
    resetn = 1'b0;
    num_edges = 32'h1f20_babb; // reserved and valid number edges
    reg_req = '0;
    {state_cmd_valid, pll_locked, tx_start, tx_done, rx_start, rx_done} = 6'h00;
    state_cmd = ST_RADIO_IDLE;
    lfsr_q = 32'h2e8d_851b;
    {ch_q, num_q, band_q} = {8'h0b, 8'h00, 8'h00};
    repeat (4) @(posedge clock);
    chk(16'({irq_flags, radio_state}), 16'(ST_RADIO_IDLE));
    resetn <= 1'b1;
    tick(2);
    chk({freq_valid, freq_half_mhz}, 16'h32ca);
    // register reset values, unmapped and read-only places
    reg_rd(ADDR_CHAN_CTRL, rd); chk(rd, 16'h002b);
    reg_rd(ADDR_ALT_NUM, rd); chk(rd, 16'h0000);
    reg_rd(ADDR_ALT_BAND, rd); chk(rd, 16'h0000);
    reg_rd(ADDR_CF_CAL, rd); chk(rd, 16'h0057);
    reg_wr(6'h20, 8'hff);
    reg_rd(6'h20, rd); chk(rd, 16'h0000);
    reg_wr(ADDR_IRQ_STATUS, 8'h03);
    reg_rd(ADDR_IRQ_STATUS, rd); chk(rd, 16'h0000);
    // random channel, number and band writes in idle, with boundary codes mixed in
    for (int i = 0; i < 48; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      key = {band_q[3:0], band_q == 8'h00 ? ch_q : num_q};
      case (lfsr_q[1:0])
        2'd0: ch_q = {3'b001, (i < 4) ? 5'(8'h0a + 8'(i % 2) * 8'h11) : lfsr_q[12:8]};
        2'd1: num_q = (i < 8) ? num_edges[(i % 4) * 8 +: 8] : lfsr_q[15:8];
        default: band_q = {4'h0, lfsr_q[3] ? lfsr_q[11:8] : {lfsr_q[2], 2'b00, lfsr_q[4]}};
      endcase
      if (lfsr_q[1:0] == 2'd0) reg_wr(ADDR_CHAN_CTRL, ch_q);
      else if (lfsr_q[1:0] == 2'd1) reg_wr(ADDR_ALT_NUM, num_q);
      else reg_wr(ADDR_ALT_BAND, {lfsr_q[15:12], band_q[3:0]});
      fc = int'(freq_change === 1'b1);
      tick(1);
      fc += int'(freq_change === 1'b1);
      chk(16'(fc), 16'(key != {band_q[3:0], band_q == 8'h00 ? ch_q : num_q}));
      tick(1);
      ef = exp_freq(ch_q[4:0], band_q[3:0], num_q);
      chk(16'(freq_valid), 16'(ef[13]));
      if (ef[13]) chk(16'(freq_half_mhz), 16'(ef[12:0]));
    end
    reg_rd(ADDR_ALT_BAND, rd); chk(rd, 16'(band_q));
    reg_wr(ADDR_ALT_BAND, 8'h00);
    reg_wr(ADDR_CHAN_CTRL, 8'h2b);
    // relock after leaving idle, then status clear on read
    go(ST_SYNTH_READY);
    pll(1'b1);
    chk(16'(irq_flags), 16'h0001);
    reg_rd(ADDR_IRQ_STATUS, rd); chk(rd, 16'h0001);
    chk(16'(irq_flags), 16'h0000);
    // frequency change in synth ready: unlock, then relock clears it
    reg_wr(ADDR_CHAN_CTRL, 8'h2c);
    tick(2);
    chk(16'(irq_flags), 16'h0002);
    pll(1'b0);
    pll(1'b1);
    chk(16'(irq_flags), 16'h0001);
    // calibration run, a zero write mid-run must not stop it
    // host side: read the register, set the start bit, write it all back
    reg_rd(ADDR_CF_CAL, rd);
    chk(rd, 16'h0057);
    reg_wr(ADDR_CF_CAL, rd | 8'h80);
    t0 = $time;
    chk(16'(cf_cal_run), 16'h0001);
    tick(1);
    chk(16'(irq_flags), 16'h0002);
    reg_wr(ADDR_CF_CAL, 8'h57);
    reg_rd(ADDR_CF_CAL, rd); chk(rd, 16'h00d7);
    fc = 0;
    while (cf_cal_run === 1'b1 && fc < 2000) begin
      tick(1);
      fc++;
    end
    chk(16'(($time - t0) / 5), 16'd1600);
    chk(16'(irq_flags), 16'h0001);
    reg_rd(ADDR_CF_CAL, rd); chk(rd, 16'h0057);
    // lock loss while transmitting aborts to synth ready
    for (int i = 0; i < 2; i++) begin
      go(i ? ST_ARETRY_READY : ST_SYNTH_READY);
      pulse(4'b1000);
      chk(16'(radio_state), 16'(i ? ST_ARETRY_TRANSMITTING : ST_TRANSMITTING));
      @(posedge clock) pll_locked <= 1'b0;
      fc = 0;
      repeat (4) begin
        tick(1);
        fc += int'(tx_abort === 1'b1);
      end
      chk(16'(fc), 16'h0001);
      chk(16'({irq_flags, radio_state}), 16'({2'b10, ST_SYNTH_READY}));
      pll(1'b1);
    end
    // successful transmit: lock edges inside the settle window raise nothing
    reg_rd(ADDR_IRQ_STATUS, rd);
    pulse(4'b1000);
    pulse(4'b0100);
    chk(16'(radio_state), 16'(ST_SYNTH_READY));
    @(posedge clock) pll_locked <= 1'b0;
    @(posedge clock) pll_locked <= 1'b1;
    tick(12);
    chk(16'(irq_flags), 16'h0000);
    // lock loss while receiving waits for relock, then returns to listening
    for (int i = 0; i < 2; i++) begin
      go(i ? ST_AACK_LISTEN : ST_LISTEN);
      pulse(4'b0010);
      chk(16'(radio_state), 16'(i ? ST_AACK_RECEIVING : ST_RECEIVING));
      pll(1'b0);
      chk(16'(radio_state), 16'(i ? ST_AACK_RECEIVING : ST_RECEIVING));
      pll(1'b1);
      chk(16'({irq_flags, radio_state}), 16'({2'b01, i ? ST_AACK_LISTEN : ST_LISTEN}));
    end
    test_done();
  end
endmodule : slc_ctrl_test
`default_nettype wire
